// *** hw/dio_map.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * of the clocked digital i/o block. definitions only.
 */
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

`define ADDR_WIDTH       3
`define DATA_WIDTH       16
`define REG_CONFIG       3'h0
`define REG_DIVIDER      3'h1
`define REG_DATA         3'h2
`define REG_STATUS       3'h3
`define REG_TIMER_LOAD   3'h4
`define REG_TIMER_COUNT  3'h5

`define CFG_WIDTH        9
`define CFG_MODE_HI      1
`define CFG_MODE_LO      0
`define CFG_EXT_CLK      2
`define CFG_ENABLE       3
`define CFG_TRIG_EN      4
`define CFG_POL_ADC      5
`define CFG_POL_DAC      6
`define CFG_POL_DIO      7
`define CFG_GATE_EDGE    8
`define CONFIG_RESET     9'h000
`define DIVIDER_RESET    16'h0064
`define TIMER_RESET      16'hffff

`define STS_XRUN         0
`define STS_EMPTY        1
`define STS_FULL         2
`define STS_RUNNING      3
`define STS_ARMED        4
`define STS_GATE         5
`define STS_CNT_OUT      6
`define STS_LEVEL_LO     7

`define SYN_EXT_CLK      16
`define SYN_TRIG_ADC     17
`define SYN_TRIG_DAC     18
`define SYN_TRIG_DIO     19
`define SYN_CNT_CLK      20
`define SYN_GATE         21
`define SYN_WIDTH        22
`define SYN_IDLE         22'h0e0000

`define TRIG_DELAY_NS    250
`define CLK_PERIOD_NS    10
`define TRIG_MAX_CYC     (`TRIG_DELAY_NS / `CLK_PERIOD_NS)

`endif

// *** hw/dio_pkg.sv ***
/*
 * types and helpers of the clocked digital i/o block.
 * assumes nothing of its surroundings.
 */
package dio_pkg;

  typedef enum logic [1:0] {
    MODE_IN16    = 2'b00,
    MODE_OUT16   = 2'b01,
    MODE_IN8OUT8 = 2'b10
  } io_mode_e;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_ARMED = 2'b01,
    RUN_GO    = 2'b10
  } run_state_e;

  // pol high selects the rising edge, low the falling edge
  function automatic logic edge_hit(input logic cur, input logic prev, input logic pol);
    edge_hit = pol ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_hit

endpackage : dio_pkg

// *** hw/sample_fifo.sv ***
/*
 * word fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   in_valid_in,
  output logic                        in_ready_out,
  input  wire logic [WIDTH-1:0]       in_data_in,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in,
  output logic [WIDTH-1:0]            out_data_out,
  output logic [$clog2(DEPTH):0]      level_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_params
    $error("sample_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_data_out  = mem[rd_ptr];
  assign level_out     = count;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : sample_fifo

// *** hw/clocked_digital_io_ports.sv ***
/*
 * clocked digital i/o: two byte ports, edge triggers, counter inputs.
 * assumes a 100 MHz ref clock; every pin is asynchronous to it.
 */
// Added by the designer: the address map and the plain strobed port.
// Behaviour
// - two byte ports: 16 in, 16 out, or 8 in plus 8 out
// - 16-bit input: port zero low byte, port one high byte
// - 8-bit input comes from port one only
// - 16-bit output: low byte on port zero, high byte on port one
// - 8-bit output is driven on port zero only
// - adc, dac and dio triggers are edge detected, polarity selectable
// - internal clock: first conversion within 250 ns plus one period
// - external clock: first conversion within 250 ns plus one clock period
// - counter clock counts a rise followed by a fall as one event
// - counter gate acts as level or edge per programmed mode
`include "dio_map.svh"

module clocked_digital_io_ports #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rstn_in,
  input  wire logic [`ADDR_WIDTH-1:0]   reg_addr_in,
  input  wire logic [`DATA_WIDTH-1:0]   reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic [`DATA_WIDTH-1:0]        reg_rdata_out,
  input  wire logic [7:0]               port0_in,
  input  wire logic [7:0]               port1_in,
  output logic [7:0]                    port0_out,
  output logic [7:0]                    port1_out,
  output logic                          port0_oe_out,
  output logic                          port1_oe_out,
  input  wire logic                     ext_clock_in,
  input  wire logic                     adc_trigger_in,
  input  wire logic                     dac_trigger_in,
  input  wire logic                     dio_trigger_in,
  input  wire logic                     counter_clock_in,
  input  wire logic                     counter_gate_in,
  output logic                          adc_start_out,
  output logic                          dac_start_out,
  output logic                          counter_output_out,
  output logic                          second_counter_output_out
);
  import dio_pkg::*;

  if (FIFO_DEPTH < 2) begin : bad_depth
    $error("clocked_digital_io_ports: fifo depth too small");
  end

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [`SYN_WIDTH-1:0]  sync1;
  logic [`SYN_WIDTH-1:0]  sync2;
  logic [`SYN_WIDTH-1:0]  prev;
  logic [`CFG_WIDTH-1:0]  config_reg;
  logic [15:0]            divider;
  logic [15:0]            div_cnt;
  logic [15:0]            timer_load;
  logic [15:0]            timer_cnt;
  logic [15:0]            out_word;
  logic [7:0]             mixed_hold;
  logic                   xrun;
  logic                   cnt_rise_seen;
  logic                   conv_sq;
  logic                   cnt_out;
  run_state_e             run_state;
  io_mode_e               mode;
  logic                   ext_sel;
  logic                   ext_tick;
  logic                   int_tick;
  logic                   tick;
  logic                   dio_edge;
  logic                   cnt_event;
  logic                   gate_ok;
  logic [15:0]            in_word;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic [15:0]            fifo_in_data;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [15:0]            fifo_out_data;
  logic [LW-1:0]          level;
  logic                   is_input;
  logic                   wr_data;
  logic                   rd_data;

  // pins are asynchronous: two flops, then only the second is looked at
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= `SYN_IDLE; // triggers idle high: no false edge out of reset
      sync2 <= `SYN_IDLE;
      prev  <= `SYN_IDLE;
    end else begin
      sync1 <= {counter_gate_in, counter_clock_in, dio_trigger_in, dac_trigger_in,
                adc_trigger_in, ext_clock_in, port1_in, port0_in};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign mode    = io_mode_e'(config_reg[`CFG_MODE_HI:`CFG_MODE_LO]);
  assign ext_sel = config_reg[`CFG_EXT_CLK];
  assign wr_data = reg_wr_in && (reg_addr_in == `REG_DATA);
  assign rd_data = reg_rd_in && (reg_addr_in == `REG_DATA);

  always_comb begin
    unique case (mode)
      MODE_IN16: is_input = 1'b1;
      MODE_OUT16: is_input = 1'b0;
      MODE_IN8OUT8: is_input = 1'b1;
      default: is_input = 1'b1;
    endcase
  end

  // edge detection on the triggers, polarity per config bit
  assign adc_start_out = edge_hit(sync2[`SYN_TRIG_ADC], prev[`SYN_TRIG_ADC],
                                  config_reg[`CFG_POL_ADC]);
  assign dac_start_out = edge_hit(sync2[`SYN_TRIG_DAC], prev[`SYN_TRIG_DAC],
                                  config_reg[`CFG_POL_DAC]);
  assign dio_edge      = edge_hit(sync2[`SYN_TRIG_DIO], prev[`SYN_TRIG_DIO],
                                  config_reg[`CFG_POL_DIO]);

  // run control: an armed block starts on the dio trigger edge
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_state <= RUN_IDLE;
    end else if (!config_reg[`CFG_ENABLE]) begin
      run_state <= RUN_IDLE;
    end else begin
      unique case (run_state)
        RUN_IDLE: run_state <= config_reg[`CFG_TRIG_EN] ? RUN_ARMED : RUN_GO;
        RUN_ARMED: if (dio_edge) begin
          run_state <= RUN_GO;
        end
        RUN_GO: run_state <= RUN_GO;
        default: run_state <= RUN_IDLE;
      endcase
    end
  end

  // internal conversion clock; restarted at run start so the first tick
  // is one full period after the trigger
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt <= `DIVIDER_RESET;
      conv_sq <= 1'b0;
    end else if (run_state != RUN_GO || div_cnt <= 16'h0001) begin
      div_cnt <= divider;
      conv_sq <= (run_state == RUN_GO) ? ~conv_sq : 1'b0;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  assign int_tick = (run_state == RUN_GO) && (div_cnt <= 16'h0001) && !ext_sel;
  // external clock: next rising edge after the run start
  assign ext_tick = (run_state == RUN_GO) && ext_sel &&
                    sync2[`SYN_EXT_CLK] && !prev[`SYN_EXT_CLK];
  assign tick = int_tick | ext_tick;
  assign second_counter_output_out = conv_sq;

  // input word assembly
  always_comb begin
    unique case (mode)
      MODE_IN8OUT8: in_word = {8'h00, sync2[15:8]};
      default: in_word = sync2[15:0];
    endcase
  end

  // fifo direction follows the mode; a full fifo drops the sample and sets xrun
  assign fifo_in_valid  = is_input ? tick : (wr_data && mode == MODE_OUT16);
  assign fifo_in_data   = is_input ? in_word : reg_wdata_in;
  assign fifo_out_ready = is_input ? rd_data : tick;

  sample_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data),
    .level_out     (level)
  );

  // output register and drivers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_word   <= '0;
      mixed_hold <= '0;
    end else begin
      if (wr_data && mode == MODE_IN8OUT8) begin
        mixed_hold <= reg_wdata_in[7:0];
      end
      if (tick && mode == MODE_OUT16 && fifo_out_valid) begin
        out_word <= fifo_out_data;
      end else if (tick && mode == MODE_IN8OUT8) begin
        out_word <= {8'h00, mixed_hold};
      end
    end
  end

  assign port0_out    = out_word[7:0];
  assign port1_out    = out_word[15:8];
  assign port0_oe_out = (mode == MODE_OUT16) || (mode == MODE_IN8OUT8);
  assign port1_oe_out = (mode == MODE_OUT16);

  // overrun/underrun flag: set beats a same-cycle clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xrun <= 1'b0;
    end else if ((fifo_in_valid && !fifo_in_ready) ||
                 (tick && mode == MODE_OUT16 && !fifo_out_valid)) begin
      xrun <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == `REG_STATUS && reg_wdata_in[`STS_XRUN]) begin
      xrun <= 1'b0;
    end
  end

  // counter clock: a full pulse is one event
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_rise_seen <= 1'b0;
    end else if (sync2[`SYN_CNT_CLK] && !prev[`SYN_CNT_CLK]) begin
      cnt_rise_seen <= 1'b1;
    end else if (cnt_event) begin
      cnt_rise_seen <= 1'b0;
    end
  end

  assign cnt_event = cnt_rise_seen && !sync2[`SYN_CNT_CLK] && prev[`SYN_CNT_CLK];
  // level mode: gate high enables counting
  assign gate_ok   = config_reg[`CFG_GATE_EDGE] | sync2[`SYN_GATE];

  // edge mode: gate rising edge reloads and restarts the count
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_cnt <= `TIMER_RESET;
      cnt_out   <= 1'b0;
    end else if (config_reg[`CFG_GATE_EDGE] && sync2[`SYN_GATE] && !prev[`SYN_GATE]) begin
      timer_cnt <= timer_load;
      cnt_out   <= 1'b0;
    end else if (cnt_event && gate_ok) begin
      timer_cnt <= timer_cnt - 16'h0001;
      if (timer_cnt == 16'h0001) begin
        cnt_out <= 1'b1;
      end
    end
  end

  assign counter_output_out = cnt_out;

  // register writes
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      config_reg <= `CONFIG_RESET;
      divider    <= `DIVIDER_RESET;
      timer_load <= `TIMER_RESET;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `REG_CONFIG: config_reg <= reg_wdata_in[`CFG_WIDTH-1:0];
        `REG_DIVIDER: divider <= (reg_wdata_in == '0) ? 16'h0001 : reg_wdata_in;
        `REG_TIMER_LOAD: timer_load <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= '0;
    end else begin
      unique case (reg_addr_in)
        `REG_CONFIG: reg_rdata_out <= 16'(config_reg);
        `REG_DIVIDER: reg_rdata_out <= divider;
        `REG_DATA: reg_rdata_out <= (is_input && fifo_out_valid) ? fifo_out_data : '0;
        `REG_STATUS: reg_rdata_out <= 16'({level, cnt_out, sync2[`SYN_GATE],
                                           run_state == RUN_ARMED, run_state == RUN_GO,
                                           !fifo_in_ready, !fifo_out_valid, xrun});
        `REG_TIMER_LOAD: reg_rdata_out <= timer_load;
        `REG_TIMER_COUNT: reg_rdata_out <= timer_cnt;
        default: reg_rdata_out <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic [15:0] wait_cnt;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt <= '0;
    end else if (run_state != RUN_GO || tick) begin
      wait_cnt <= '0;
    end else if (wait_cnt != 16'hffff) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  port_dir_a: assert property (mode == MODE_IN16 |-> !port0_oe_out && !port1_oe_out)
    else $error("ports driven in 16-bit input");
  in16_word_a: assert property (tick && mode == MODE_IN16 && fifo_in_ready
    |=> level == $past(level) + 1'b1 || $past(rd_data))
    else $error("16-bit capture lost");
  in8_word_a: assert property (fifo_in_valid && mode == MODE_IN8OUT8 && level == '0
    |=> fifo_out_data == {8'h00, $past(sync2[15:8])})
    else $error("8-bit input not from port one");
  out16_word_a: assert property (tick && mode == MODE_OUT16 && fifo_out_valid
    |=> {port1_out, port0_out} == $past(fifo_out_data) && port1_oe_out)
    else $error("16-bit output wrong");
  out8_port_a: assert property (mode == MODE_IN8OUT8 |-> port0_oe_out && !port1_oe_out)
    else $error("8-bit output pins wrong");
  trig_edge_a: assert property (run_state == RUN_ARMED && config_reg[`CFG_ENABLE] &&
    $fell(dio_trigger_in) && !config_reg[`CFG_POL_DIO] |-> ##[1:4] run_state == RUN_GO)
    else $error("trigger edge missed");
  int_first_a: assert property (!ext_sel |-> wait_cnt <= divider)
    else $error("internal clock first conversion late");
  ext_first_a: assert property (run_state == RUN_GO && ext_sel && $rose(ext_clock_in)
    |-> ##[1:4] tick)
    else $error("external clock event missed");
  cnt_pulse_a: assert property (cnt_event |=> !cnt_rise_seen && !cnt_event)
    else $error("one pulse counted twice");
  gate_level_a: assert property (cnt_event && !config_reg[`CFG_GATE_EDGE] &&
    !sync2[`SYN_GATE] |=> timer_cnt == $past(timer_cnt))
    else $error("counted with gate low");
  xrun_set_a: assert property (fifo_in_valid && !fifo_in_ready |=> xrun)
    else $error("overrun not flagged");

endmodule : clocked_digital_io_ports

// *** test/ext_equipment.sv ***
/*
 * model of the external digital equipment: port data, conversion clock, triggers.
 * assumes the bench resolves the port pins from the device's output enables.
 */
module ext_equipment (
  input  wire logic        run_in,
  input  wire logic [15:0] word_in,
  input  wire logic [2:0]  trig_low_in,
  output logic             ext_clock_out,
  output logic [7:0]       port0_out,
  output logic [7:0]       port1_out,
  output logic [2:0]       trig_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // pulled up, so a trigger idles high and only pulses low
  assign trig_out = ~trig_low_in;

  // clock stands still between frames; data moves on the fall, far from the rise
  initial begin
    ext_clock_out = 1'b0;
    port0_out = 8'h00;
    port1_out = 8'h00;
    forever begin
      wait (run_in);
      // keeps both clock edges off the reference clock's rising edges
      #3;
      while (run_in) begin
        #80;
        ext_clock_out = 1'b1;
        #80;
        ext_clock_out = 1'b0;
        {port1_out, port0_out} = word_in;
      end
    end
  end
endmodule : ext_equipment

// *** test/test_clocked_digital_io_ports.sv ***
/*
 * self-checking bench of the clocked digital i/o block.
 * assumes the equipment model beside it and a 100 MHz reference clock.
 */
`include "dio_map.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end

module test_clocked_digital_io_ports;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_n, wr, rd, cclk, cgate, run;
  logic [2:0]  addr, tlow;
  logic [15:0] wdata, rdata;
  wire  [7:0]  p0_out, p1_out, e0, e1;
  wire         oe0, oe1, eclk, adc_st, dac_st, cnt_o, sq_o;
  wire  [2:0]  trig;
  int          mismatches, checks_done, mode_m, n_ext;
  int          n_st[2];
  logic [15:0] q[$];
  logic [15:0] w[2];
  logic [15:0] rv[8];
  logic [7:0]  held;
  logic [31:0] xs = 32'd76;
  // the device owns a pin whenever its enable is high
  wire  [7:0]  pin0 = oe0 ? p0_out : e0;
  wire  [7:0]  pin1 = oe1 ? p1_out : e1;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    next_rand = x ^ (x << 5);
  endfunction : next_rand

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  clocked_digital_io_ports dut (
    .ref_clk_in(clk), .rstn_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .port0_in(pin0),
    .port1_in(pin1), .port0_out(p0_out), .port1_out(p1_out), .port0_oe_out(oe0),
    .port1_oe_out(oe1), .ext_clock_in(eclk), .adc_trigger_in(trig[0]),
    .dac_trigger_in(trig[1]), .dio_trigger_in(trig[2]), .counter_clock_in(cclk),
    .counter_gate_in(cgate), .adc_start_out(adc_st), .dac_start_out(dac_st),
    .counter_output_out(cnt_o), .second_counter_output_out(sq_o));

  ext_equipment far_end (
    .run_in(run), .word_in(xs[15:0]), .trig_low_in(tlow), .ext_clock_out(eclk),
    .port0_out(e0), .port1_out(e1), .trig_out(trig));

  // reference model: one word per clock rise, dropped once eight are waiting
  always @(posedge eclk) begin
    n_ext <= n_ext + 1;
    xs <= next_rand(xs);
    if (mode_m != 0 && q.size() < 8) begin
      q.push_back(mode_m == 1 ? {pin1, pin0} : {8'h00, pin1});
    end
  end

  always @(posedge clk) begin
    n_st[0] <= n_st[0] + int'(adc_st);
    n_st[1] <= n_st[1] + int'(dac_st);
  end

  task automatic complete_run;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata & m, e)
  endtask : rd_chk

  task automatic ticks(input int n);
    int start;
    start = n_ext;
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < n * 20 + 20 && n_ext - start < n; i++) @(posedge clk);
    run <= 1'b0;
    if (n_ext - start < n) begin
      mismatches++;
      $display("BAD %0t no conversion clock", $time);
      complete_run;
    end
    repeat (12) @(posedge clk);
  endtask : ticks

  task automatic trig_chk(input int i, input logic pol);
    int b;
    b = n_st[i];
    wr_reg(`REG_CONFIG, 16'(pol) << (5 + i));
    @(posedge clk);
    tlow[i] <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(n_st[i] - b, pol ? 0 : 1)
    tlow[i] <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(n_st[i] - b, 1)
  endtask : trig_chk

  task automatic pulse_count(input logic [15:0] mid, input logic [15:0] fin);
    @(posedge clk);
    cclk <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(`REG_TIMER_COUNT, 16'hffff, mid);
    @(posedge clk);
    cclk <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(`REG_TIMER_COUNT, 16'hffff, fin);
  endtask : pulse_count

  initial begin
    rst_n = 1'b0;
    {addr, wdata, wr, rd, cclk, cgate, run, tlow} = '0;
    {mismatches, checks_done, mode_m, n_ext} = '0;
    n_st = '{0, 0};
    rv = '{16'h0000, `DIVIDER_RESET, 16'h0000, 16'h0002, `TIMER_RESET, `TIMER_RESET,
           16'h0000, 16'h0000};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) rd_chk(3'(i), i == 3 ? 16'h079f : 16'hffff, rv[i]);
    wr_reg(`REG_TIMER_COUNT, 16'h1234);
    wr_reg(3'h6, 16'hbeef);
    rd_chk(`REG_TIMER_COUNT, 16'hffff, `TIMER_RESET);
    rd_chk(3'h6, 16'hffff, 16'h0000);
    // the spare mode code counts as an input: both ports released
    wr_reg(`REG_CONFIG, 16'h0003);
    rd_chk(`REG_CONFIG, 16'hffff, 16'h0003);
    `CHK({oe1, oe0}, 2'b00)
    // 16 in on the external clock: overfill, then drain
    mode_m = 1;
    wr_reg(`REG_CONFIG, 16'h000c);
    ticks(10);
    mode_m = 0;
    rd_chk(`REG_STATUS, 16'h079f, 16'h040d);
    wr_reg(`REG_CONFIG, 16'h0000);
    for (int i = 0; i < 8; i++) rd_chk(`REG_DATA, 16'hffff, q.pop_front());
    rd_chk(`REG_STATUS, 16'h079f, 16'h0003);
    wr_reg(`REG_STATUS, 16'h0001);
    rd_chk(`REG_STATUS, 16'h079f, 16'h0002);
    // 8 in plus 8 out
    held = xs[15:8];
    mode_m = 2;
    wr_reg(`REG_CONFIG, 16'h000e);
    wr_reg(`REG_DATA, {8'h00, held});
    ticks(2);
    mode_m = 0;
    `CHK({oe1, oe0, p0_out}, {2'b01, held})
    wr_reg(`REG_CONFIG, 16'h0000);
    for (int i = 0; i < 2; i++) rd_chk(`REG_DATA, 16'hffff, q.pop_front());
    // 16 out; the third tick finds the buffer empty and keeps the last word
    w = '{xs[15:0], xs[31:16]};
    wr_reg(`REG_CONFIG, 16'h000d);
    wr_reg(`REG_DATA, w[0]);
    wr_reg(`REG_DATA, w[1]);
    for (int k = 0; k < 3; k++) begin
      ticks(1);
      `CHK({oe1, oe0, p1_out, p0_out}, {2'b11, w[k < 2 ? k : 1]})
    end
    rd_chk(`REG_STATUS, 16'h0001, 16'h0001);
    wr_reg(`REG_CONFIG, 16'h0000);
    wr_reg(`REG_STATUS, 16'h0001);
    for (int i = 0; i < 4; i++) trig_chk(i / 2, 1'(i % 2));
    // armed run waits for the port trigger's falling edge
    wr_reg(`REG_DIVIDER, 16'h0004);
    wr_reg(`REG_CONFIG, 16'h0019);
    repeat (20) @(posedge clk);
    `CHK(sq_o, 1'b0)
    @(posedge clk);
    tlow[2] <= 1'b1;
    for (int i = 0; i < `TRIG_MAX_CYC + 4 && sq_o !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(sq_o, 1'b1)
    tlow[2] <= 1'b0;
    wr_reg(`REG_CONFIG, 16'h0000);
    // counter: gate edge reloads, whole pulses count, low level gate holds
    wr_reg(`REG_TIMER_LOAD, 16'h0003);
    wr_reg(`REG_CONFIG, 16'h0100);
    @(posedge clk);
    cgate <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(`REG_TIMER_COUNT, 16'hffff, 16'h0003);
    for (int k = 1; k < 4; k++) pulse_count(16'(4 - k), 16'(3 - k));
    `CHK(cnt_o, 1'b1)
    wr_reg(`REG_CONFIG, 16'h0000);
    @(posedge clk);
    cgate <= 1'b0;
    pulse_count(16'h0000, 16'h0000);
    complete_run;
  end
endmodule : test_clocked_digital_io_ports
